/* bench/axis_field_model.sv */
// Field side of the supervisor: stop contact, driver fault pins,
// switches and probe. Levels only; the bench sets what happens.
`timescale 1ns/1ps
module axis_field_model (
  // Commands from the bench
  input wire logic estop_press_in,
  input wire logic estop_no_in,
  input wire logic [7:0] fault_in,
  input wire logic [7:0] fault_low_in,
  input wire logic [7:0] home_hit_in,
  input wire logic [7:0] limit_hit_in,
  input wire logic probe_touch_in,
  // Pins toward the supervisor
  output logic estop_pin_out,
  output logic [7:0] drv_err_pin_out,
  output logic [7:0] home_pin_out,
  output logic [7:0] limit_pin_out,
  output logic probe_pin_out
);
  // A closed contact reads high; pressing opens a closed contact
  assign estop_pin_out = estop_no_in ? estop_press_in : ~estop_press_in;
  // Drivers with active-low fault outputs idle high
  assign drv_err_pin_out = fault_in ^ fault_low_in;
  assign home_pin_out = home_hit_in;
  assign limit_pin_out = limit_hit_in;
  assign probe_pin_out = probe_touch_in;
endmodule

/* bench/tb_step_axis_io_supervisor.sv */
// Self-checking bench of the axis I/O supervisor over APB.
// Assumes a shortened tick of ten clocks.
`timescale 1ns/1ps
`include "step_axis_io_supervisor_defs.svh"
module tb_step_axis_io_supervisor;
  import step_axis_io_supervisor_pkg::*;
  localparam int TK = 10;
  logic clk = 0, rstn = 0, psel = 0, pen = 0, pwr = 0, mb = 0, prb = 0;
  logic est = 0, eno = 0, pready, perr, irq, cp, po, run, rerr;
  logic est_pin, prb_pin;
  logic [7:0] paddr = 0, flt = 0, alow = 0, hh = 0, lh = 0, stp = 0;
  logic [7:0] dr = 0, hd = 0, so, dout, en, hf, lf, bos, done, blr, bms;
  logic [7:0] syo, err_pin, home_pin, lim_pin;
  logic [15:0] blw, bla;
  logic [31:0] pwdata = 0, prdata, rdat;
  int error_cnt = 0, num_checks = 0, tmo = 0;
  always #2 clk = ~clk;
  axis_field_model u_axis_field_model (.estop_press_in(est),
    .estop_no_in(eno), .fault_in(flt), .fault_low_in(alow),
    .home_hit_in(hh), .limit_hit_in(lh), .probe_touch_in(prb),
    .estop_pin_out(est_pin), .drv_err_pin_out(err_pin),
    .home_pin_out(home_pin), .limit_pin_out(lim_pin),
    .probe_pin_out(prb_pin));
  step_axis_io_supervisor #(.TICK_CYC(TK)) u_step_axis_io_supervisor (
    .ref_clk_in(clk), .rstn_in(rstn), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(perr),
    .irq_out(irq), .home_in(home_pin), .limit_in(lim_pin),
    .estop_in(est_pin), .drv_err_in(err_pin), .probe_in(prb_pin),
    .step_in(stp), .dir_in(dr), .homing_done_in(hd),
    .move_boundary_in(mb), .step_out(so), .dir_out(dout),
    .axis_en_out(en), .charge_pump_out(cp), .home_filt_out(hf),
    .limit_filt_out(lf), .probe_out(po), .running_out(run),
    .backoff_step_out(bos), .axis_done_out(done), .bl_req_out(blr),
    .bl_width_out(blw), .bl_accel_out(bla), .buf_ms_out(bms),
    .sync_out(syo));
  task automatic finish_test;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // About sixty times the expected run length
  always @(posedge clk)
  begin
    tmo <= tmo + 1;
    if (tmo == 30000)
    begin
      error_cnt++;
      finish_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  // Sample a settled nanosecond after the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rdat = prdata;
    rerr = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic pulse_boundary;
    @(posedge clk);
    mb <= 1'b1;
    @(posedge clk);
    mb <= 1'b0;
  endtask
  task automatic t_regs;
    rd(`OFF_CTRL);
    chk(rdat, 32'h0);
    chk(bms, 8'h80);
    wr(`OFF_BUF_MS, 32'hFF);
    rd(`OFF_BUF_MS);
    chk(rdat, 32'h80);
    rd(`OFF_BL_ACCEL);
    chk(rdat, 32'h1);
    rd(8'h3C);
    chk(rerr, 1'b1);
    wr(`OFF_FILTER, 32'hFF);
    rd(`OFF_FILTER);
    chk(rdat, 32'hFE);
  endtask
  task automatic t_filter;
    wr(`OFF_CTRL, 32'h80);
    wr(`OFF_FILTER, 32'h0);
    @(posedge clk);
    hh <= 8'h01;
    cyc(4);
    chk(hf, 8'h01);
    wr(`OFF_FILTER, 32'h3);
    @(posedge clk);
    lh <= 8'h02;
    cyc(15);
    chk(lf, 8'h00);
    cyc(25);
    chk(lf, 8'h02);
    @(posedge clk);
    lh <= 8'h00;
    hh <= 8'h00;
    cyc(4);
    chk(lf, 8'h00);
  endtask
  task automatic t_enable;
    wr(`OFF_CTRL, 32'h201);
    cyc(3);
    chk(en, 8'hFF);
    wr(`OFF_EN_POL, 32'h0F);
    cyc(3);
    chk(en, 8'hF0);
    wr(`OFF_HOST_EN, 32'h05);
    wr(`OFF_CTRL, 32'h8);
    cyc(3);
    chk(en, 8'h0A);
    wr(`OFF_EN_POL, 32'h0);
    wr(`OFF_CTRL, 32'h0);
  endtask
  task automatic t_pump;
    int n;
    logic p;
    wr(`OFF_MASK, 32'h1);
    wr(`OFF_CTRL, 32'h5);
    cyc(3);
    n = 0;
    p = cp;
    repeat (10 * TK)
    begin
      cyc(1);
      n += (cp !== p);
      p = cp;
    end
    chk(32'(n), 32'd10);
    @(posedge clk);
    est <= 1'b1;
    cyc(6);
    chk({run, en}, 9'h000);
    chk(irq, 1'b1);
    p = cp;
    n = 0;
    repeat (3 * TK)
    begin
      cyc(1);
      n += (cp !== p);
    end
    chk(32'(n), 32'd0);
    chk(cp, 1'b0);
    wr(`OFF_STATUS, 32'h1);
    cyc(1);
    chk(irq, 1'b0);
    @(posedge clk);
    est <= 1'b0;
    eno <= 1'b1;
    wr(`OFF_CTRL, 32'h2);
    wr(`OFF_CTRL, 32'h3);
    cyc(3);
    chk(run, 1'b1);
    @(posedge clk);
    est <= 1'b1;
    cyc(6);
    chk(run, 1'b0);
    @(posedge clk);
    est <= 1'b0;
    eno <= 1'b0;
    wr(`OFF_CTRL, 32'h0);
  endtask
  task automatic t_err;
    wr(`OFF_CTRL, 32'h1);
    @(posedge clk);
    flt <= 8'h01;
    cyc(6);
    chk(run, 1'b1);
    @(posedge clk);
    flt <= 8'h00;
    alow <= 8'h01;
    wr(`OFF_ERR_INV, 32'h1);
    wr(`OFF_ERR_STOP, 32'h1);
    cyc(6);
    chk(run, 1'b1);
    @(posedge clk);
    flt <= 8'h01;
    cyc(6);
    chk(run, 1'b0);
    rd(`OFF_STATUS);
    chk(rdat[1], 1'b1);
    wr(`OFF_ERR_STOP, 32'h0);
    wr(`OFF_STATUS, 32'h1F);
  endtask
  task automatic t_backoff;
    int n;
    wr(`OFF_BACKOFF, 32'h3);
    @(posedge clk);
    hd <= 8'h02;
    @(posedge clk);
    hd <= 8'h00;
    n = 0;
    repeat (6 * TK)
    begin
      cyc(1);
      n += (bos[1] === 1'b1);
    end
    chk(32'(n), 32'd3);
    chk(done, 8'h02);
    rd(`OFF_STATUS);
    chk(rdat[2], 1'b1);
  endtask
  task automatic t_sync;
    wr(`OFF_CTRL, 32'h211);
    stp <= 8'hFF;
    cyc(3);
    chk(so, 8'h7F);
    wr(`OFF_SYNC_CMD, 32'h102);
    cyc(2);
    chk(syo, 8'h00);
    pulse_boundary();
    cyc(2);
    chk(syo, 8'h04);
    wr(`OFF_SYNC_CMD, 32'h002);
    wr(`OFF_SYNC_CMD, 32'h105);
    pulse_boundary();
    cyc(2);
    chk(syo, 8'h20);
    wr(`OFF_CTRL, 32'h001);
    cyc(3);
    chk(so, 8'h07);
    wr(`OFF_CTRL, 32'h101);
    cyc(3);
    chk(so, 8'h0F);
  endtask
  task automatic t_bl;
    int n;
    wr(`OFF_CTRL, 32'h221);
    wr(`OFF_BL_WIDTH, 32'h40);
    wr(`OFF_BL_ACCEL, 32'h5);
    dr <= 8'h01;
    n = 0;
    repeat (4)
    begin
      cyc(1);
      n += (blr[0] === 1'b1);
    end
    chk(32'(n), 32'd1);
    chk({blw, bla}, 32'h0040_0005);
    chk(dout, 8'h01);
  endtask
  task automatic t_probe;
    wr(`OFF_CTRL, 32'h40);
    cyc(4);
    chk(po, 1'b1);
    @(posedge clk);
    prb <= 1'b1;
    cyc(4);
    chk(po, 1'b0);
  endtask
  initial
  begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    t_regs();
    t_filter();
    t_enable();
    t_pump();
    t_err();
    t_backoff();
    t_sync();
    t_bl();
    t_probe();
    finish_test();
  end
endmodule

/* src/step_axis_io_supervisor.sv */
// Axis I/O supervisor: switch filtering, stop inputs, charge pump,
// axis enables, back-off, backlash requests and synchronized outputs.
// Assumes an APB master on ref_clk_in and a motion engine on the same
// clock; switch, stop, error and probe pins are asynchronous.
`timescale 1ns/1ps
`include "step_axis_io_supervisor_defs.svh"
module step_axis_io_supervisor
  import step_axis_io_supervisor_pkg::*;
#(
  parameter int TICK_CYC = `TICK_CYCLES
)(
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output logic irq_out,
  // Switch and driver pins
  input wire logic [7:0] home_in,
  input wire logic [7:0] limit_in,
  input wire logic estop_in,
  input wire logic [7:0] drv_err_in,
  input wire logic probe_in,
  // Motion engine side
  input wire logic [7:0] step_in,
  input wire logic [7:0] dir_in,
  input wire logic [7:0] homing_done_in,
  input wire logic move_boundary_in,
  // Outputs
  output logic [7:0] step_out,
  output logic [7:0] dir_out,
  output logic [7:0] axis_en_out,
  output logic charge_pump_out,
  output logic [7:0] home_filt_out,
  output logic [7:0] limit_filt_out,
  output logic probe_out,
  output logic running_out,
  output logic [7:0] backoff_step_out,
  output logic [7:0] axis_done_out,
  output logic [7:0] bl_req_out,
  output logic [15:0] bl_width_out,
  output logic [15:0] bl_accel_out,
  output logic [7:0] buf_ms_out,
  output logic [7:0] sync_out
);

  function automatic logic [7:0] filt_step(input logic act,
    input logic [7:0] cnt, input logic [7:0] lim, input logic tk);
    if (!act)
      filt_step = 8'h00;
    else if (tk && (cnt < lim))
      filt_step = cnt + 8'h01;
    else
      filt_step = cnt;
  endfunction

  function automatic logic [7:0] clamp8(input logic [7:0] v,
    input logic [7:0] mx);
    clamp8 = (v > mx) ? mx : v;
  endfunction

  // Pin synchronisers
  logic [`SYNC_STAGES-1:0] pin_meta_ff;
  logic [`SYNC_STAGES-1:0] pin_sync_ff;
  always_ff @(posedge ref_clk_in or negedge rstn_in)
    if (!rstn_in)
    begin
      pin_meta_ff <= '0;
      pin_sync_ff <= '0;
    end
    else
    begin
      pin_meta_ff <= {probe_in, estop_in, drv_err_in, limit_in, home_in};
      pin_sync_ff <= pin_meta_ff;
    end
  wire axis_vec_t home_s = pin_sync_ff[7:0];
  wire axis_vec_t limit_s = pin_sync_ff[15:8];
  wire axis_vec_t drv_s = pin_sync_ff[23:16];
  wire estop_s = pin_sync_ff[24];
  wire probe_s = pin_sync_ff[25];

  // Tick divider, 0.1 ms
  logic [15:0] tick_cnt_ff;
  wire tick = (tick_cnt_ff == 16'(TICK_CYC - 1));
  always_ff @(posedge ref_clk_in or negedge rstn_in)
    if (!rstn_in)
      tick_cnt_ff <= 16'h0000;
    else
      tick_cnt_ff <= tick ? 16'h0000 : tick_cnt_ff + 16'h0001;

  // Registers
  logic [`CTRL_W-1:0] ctrl_ff;
  logic [7:0] filter_ff, buf_ms_ff;
  axis_vec_t host_en_ff, en_pol_ff, err_stop_ff, err_inv_ff;
  logic [15:0] backoff_ff, bl_accel_ff, bl_width_ff;
  logic [`ST_W-1:0] status_ff, mask_ff;

  wire wr_en = psel_in && penable_in && pwrite_in;
  wire sel_ctrl = wr_en && (paddr_in == `OFF_CTRL);
  wire sel_filter = wr_en && (paddr_in == `OFF_FILTER);
  wire sel_host_en = wr_en && (paddr_in == `OFF_HOST_EN);
  wire sel_en_pol = wr_en && (paddr_in == `OFF_EN_POL);
  wire sel_err_stop = wr_en && (paddr_in == `OFF_ERR_STOP);
  wire sel_err_inv = wr_en && (paddr_in == `OFF_ERR_INV);
  wire sel_backoff = wr_en && (paddr_in == `OFF_BACKOFF);
  wire sel_bl_accel = wr_en && (paddr_in == `OFF_BL_ACCEL);
  wire sel_bl_width = wr_en && (paddr_in == `OFF_BL_WIDTH);
  wire sel_sync = wr_en && (paddr_in == `OFF_SYNC_CMD);
  wire sel_status = wr_en && (paddr_in == `OFF_STATUS);
  wire sel_mask = wr_en && (paddr_in == `OFF_MASK);
  wire sel_buf = wr_en && (paddr_in == `OFF_BUF_MS);

  wire estop_inv = ctrl_ff[`CTRL_ESTOP_INV];
  wire cp_en = ctrl_ff[`CTRL_CP_EN];
  wire host_mode = ctrl_ff[`CTRL_HOST_EN];
  wire sync_en = ctrl_ff[`CTRL_SYNC_EN];
  wire bl_en = ctrl_ff[`CTRL_BL_EN];
  wire probe_inv = ctrl_ff[`CTRL_PROBE_INV];
  wire ext_io = ctrl_ff[`CTRL_EXT_IO];
  wire engine_var_t eng_var =
    engine_var_t'(ctrl_ff[`CTRL_VAR_HI:`CTRL_VAR_LO]);

  // Channel mask per engine variant; ch8 lost to sync data
  wire axis_vec_t var_mask = (eng_var == VAR_INT3) ? 8'h07 :
    (eng_var == VAR_EXT4) ? 8'h0F : 8'hFF;
  wire axis_vec_t chan_mask = sync_en ? (var_mask & 8'h7F)
    : var_mask;

  // Stop conditions
  wire estop_act = ~(estop_s ^ estop_inv);
  wire axis_vec_t err_act = err_stop_ff & (drv_s ^ err_inv_ff);
  wire err_any = |(err_act & chan_mask);
  logic running_ff;
  // A stop drops the run request so motion never resumes by itself
  wire run_kill = estop_act || err_any;

  always_ff @(posedge ref_clk_in or negedge rstn_in)
    if (!rstn_in)
      ctrl_ff <= `CTRL_RST;
    else if (sel_ctrl)
      ctrl_ff <= {pwdata_in[`CTRL_W-1:1], pwdata_in[`CTRL_RUN] & ~run_kill};
    else if (run_kill)
      ctrl_ff[`CTRL_RUN] <= 1'b0;

  always_ff @(posedge ref_clk_in or negedge rstn_in)
    if (!rstn_in)
    begin
      filter_ff <= 8'h00;
      buf_ms_ff <= `BUF_MS_RST;
      host_en_ff <= 8'h00;
      en_pol_ff <= 8'h00;
      err_stop_ff <= 8'h00;
      err_inv_ff <= 8'h00;
    end
    else
    begin
      if (sel_filter)
        filter_ff <= clamp8(pwdata_in[7:0], `FILTER_MAX);
      if (sel_buf)
        buf_ms_ff <= clamp8(pwdata_in[7:0], `BUF_MS_MAX);
      if (sel_host_en)
        host_en_ff <= pwdata_in[7:0];
      if (sel_en_pol)
        en_pol_ff <= pwdata_in[7:0];
      if (sel_err_stop)
        err_stop_ff <= pwdata_in[7:0];
      if (sel_err_inv)
        err_inv_ff <= pwdata_in[7:0];
    end

  always_ff @(posedge ref_clk_in or negedge rstn_in)
    if (!rstn_in)
    begin
      backoff_ff <= 16'h0000;
      bl_accel_ff <= 16'h0001;
      bl_width_ff <= 16'h0000;
      mask_ff <= '0;
    end
    else
    begin
      if (sel_backoff)
        backoff_ff <= pwdata_in[15:0];
      if (sel_bl_accel)
        bl_accel_ff <= pwdata_in[15:0];
      if (sel_bl_width)
        bl_width_ff <= pwdata_in[15:0];
      if (sel_mask)
        mask_ff <= pwdata_in[`ST_W-1:0];
    end

  // Running state, charge pump and enables
  always_ff @(posedge ref_clk_in or negedge rstn_in)
    if (!rstn_in)
      running_ff <= 1'b0;
    else
      running_ff <= ctrl_ff[`CTRL_RUN] && !run_kill;

  // A 0.1 ms half period gives the 5 kHz square wave
  logic cp_ff;
  always_ff @(posedge ref_clk_in or negedge rstn_in)
    if (!rstn_in)
      cp_ff <= 1'b0;
    else if (!(running_ff && cp_en))
      cp_ff <= 1'b0;
    else if (tick)
      cp_ff <= ~cp_ff;

  wire axis_vec_t en_src = host_mode ? host_en_ff
    : {8{running_ff}};
  logic [7:0] axis_en_ff;
  always_ff @(posedge ref_clk_in or negedge rstn_in)
    if (!rstn_in)
      axis_en_ff <= 8'h00;
    else
      axis_en_ff <= (en_src & chan_mask) ^ en_pol_ff;

  // Home and limit filters; external dedicated inputs only with IO
  axis_vec_t home_act, limit_act;
  assign home_act = ext_io ? home_s : 8'h00;
  assign limit_act = ext_io ? limit_s : 8'h00;
  logic [7:0] home_cnt_ff [8];
  logic [7:0] limit_cnt_ff [8];
  axis_vec_t home_f, limit_f;
  always_ff @(posedge ref_clk_in or negedge rstn_in)
    if (!rstn_in)
      for (int i = 0; i < 8; i++)
      begin
        home_cnt_ff[i] <= 8'h00;
        limit_cnt_ff[i] <= 8'h00;
      end
    else
      for (int i = 0; i < 8; i++)
      begin
        home_cnt_ff[i] <= filt_step(home_act[i], home_cnt_ff[i],
          filter_ff, tick);
        limit_cnt_ff[i] <= filt_step(limit_act[i], limit_cnt_ff[i],
          filter_ff, tick);
      end
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      home_f[i] = (filter_ff == 8'h00) ? home_act[i]
        : (home_act[i] && (home_cnt_ff[i] >= filter_ff));
      limit_f[i] = (filter_ff == 8'h00) ? limit_act[i]
        : (limit_act[i] && (limit_cnt_ff[i] >= filter_ff));
    end
  end

  // Probe
  wire probe_act = probe_s ^ probe_inv;
  logic probe_ff, estop_prev_ff, err_prev_ff;
  axis_vec_t limit_prev_ff;

  // Back-off after homing, one step per tick
  logic [15:0] bo_cnt_ff [8];
  axis_vec_t bo_busy_ff, bo_step_ff, done_ff;
  wire axis_vec_t bo_fin = bo_busy_ff &
    {8{tick}} & {bo_cnt_ff[7] == 16'h0001, bo_cnt_ff[6] == 16'h0001,
    bo_cnt_ff[5] == 16'h0001, bo_cnt_ff[4] == 16'h0001,
    bo_cnt_ff[3] == 16'h0001, bo_cnt_ff[2] == 16'h0001,
    bo_cnt_ff[1] == 16'h0001, bo_cnt_ff[0] == 16'h0001};
  wire axis_vec_t bo_zero_done = homing_done_in & {8{backoff_ff == 16'h0000}};
  always_ff @(posedge ref_clk_in or negedge rstn_in)
    if (!rstn_in)
    begin
      for (int i = 0; i < 8; i++)
        bo_cnt_ff[i] <= 16'h0000;
      bo_busy_ff <= 8'h00;
      bo_step_ff <= 8'h00;
      done_ff <= 8'h00;
    end
    else
      for (int i = 0; i < 8; i++)
      begin
        bo_step_ff[i] <= bo_busy_ff[i] && tick;
        if (homing_done_in[i])
        begin
          bo_cnt_ff[i] <= backoff_ff;
          bo_busy_ff[i] <= (backoff_ff != 16'h0000);
          done_ff[i] <= (backoff_ff == 16'h0000);
        end
        else if (bo_busy_ff[i] && tick)
        begin
          bo_cnt_ff[i] <= bo_cnt_ff[i] - 16'h0001;
          bo_busy_ff[i] <= !bo_fin[i];
          done_ff[i] <= bo_fin[i];
        end
      end

  // Backlash request on direction reversal
  axis_vec_t dir_prev_ff, bl_req_ff;
  always_ff @(posedge ref_clk_in or negedge rstn_in)
    if (!rstn_in)
    begin
      dir_prev_ff <= 8'h00;
      bl_req_ff <= 8'h00;
    end
    else
    begin
      dir_prev_ff <= dir_in;
      bl_req_ff <= (dir_in ^ dir_prev_ff) & chan_mask &
        {8{bl_en}};
    end

  // Synchronized outputs: queued per move, applied at the boundary
  axis_vec_t pend_set_ff, pend_clr_ff, sync_ff;
  wire axis_vec_t cmd_bit = 8'h01 << pwdata_in[`SYNC_IDX_HI:0];
  wire sync_code_t cmd_code = sync_code_t'(pwdata_in[`SYNC_CODE_BIT]);
  wire apply = move_boundary_in && sync_en;
  wire axis_vec_t pset_base = apply ? 8'h00 : pend_set_ff;
  wire axis_vec_t pclr_base = apply ? 8'h00 : pend_clr_ff;
  always_ff @(posedge ref_clk_in or negedge rstn_in)
    if (!rstn_in)
    begin
      pend_set_ff <= 8'h00;
      pend_clr_ff <= 8'h00;
      sync_ff <= 8'h00;
    end
    else
    begin
      if (apply)
        sync_ff <= (sync_ff & ~pend_clr_ff) | pend_set_ff;
      if (sel_sync && sync_en && (cmd_code == SYNC_SET_CODE))
      begin
        pend_set_ff <= pset_base | cmd_bit;
        pend_clr_ff <= pclr_base & ~cmd_bit;
      end
      else if (sel_sync && sync_en)
      begin
        pend_set_ff <= pset_base & ~cmd_bit;
        pend_clr_ff <= pclr_base | cmd_bit;
      end
      else
      begin
        pend_set_ff <= pset_base;
        pend_clr_ff <= pclr_base;
      end
    end

  // Sticky status, write one to clear; a new event wins
  wire [`ST_W-1:0] events = {|(limit_f & ~limit_prev_ff & chan_mask),
    probe_act & ~probe_ff, |(bo_fin | bo_zero_done),
    err_any & ~err_prev_ff, estop_act & ~estop_prev_ff};
  always_ff @(posedge ref_clk_in or negedge rstn_in)
    if (!rstn_in)
    begin
      status_ff <= '0;
      probe_ff <= 1'b0;
      // Stop counts as active in reset, so the idle contact raises no event
      estop_prev_ff <= 1'b1;
      err_prev_ff <= 1'b0;
      limit_prev_ff <= 8'h00;
    end
    else
    begin
      status_ff <= (status_ff & ~(sel_status ?
        pwdata_in[`ST_W-1:0] : '0)) | events;
      probe_ff <= probe_act;
      estop_prev_ff <= estop_act;
      err_prev_ff <= err_any;
      limit_prev_ff <= limit_f;
    end

  // Read data, loaded in the setup phase
  wire rd_hit = (paddr_in <= `OFF_SYNC_OUT) && (paddr_in[1:0] == 2'h0);
  wire [31:0] rd_word =
    (paddr_in == `OFF_CTRL) ? {22'h0, ctrl_ff} :
    (paddr_in == `OFF_FILTER) ? {24'h0, filter_ff} :
    (paddr_in == `OFF_HOST_EN) ? {24'h0, host_en_ff} :
    (paddr_in == `OFF_EN_POL) ? {24'h0, en_pol_ff} :
    (paddr_in == `OFF_ERR_STOP) ? {24'h0, err_stop_ff} :
    (paddr_in == `OFF_ERR_INV) ? {24'h0, err_inv_ff} :
    (paddr_in == `OFF_BACKOFF) ? {16'h0, backoff_ff} :
    (paddr_in == `OFF_BL_ACCEL) ? {16'h0, bl_accel_ff} :
    (paddr_in == `OFF_BL_WIDTH) ? {16'h0, bl_width_ff} :
    (paddr_in == `OFF_STATUS) ? {27'h0, status_ff} :
    (paddr_in == `OFF_MASK) ? {27'h0, mask_ff} :
    (paddr_in == `OFF_STATE) ? {6'h0, probe_act, running_ff,
      limit_f, home_f, bo_busy_ff} :
    (paddr_in == `OFF_BUF_MS) ? {24'h0, buf_ms_ff} :
    (paddr_in == `OFF_SYNC_OUT) ? {24'h0, sync_ff} : 32'h0000_0000;
  logic [31:0] prdata_ff;
  always_ff @(posedge ref_clk_in or negedge rstn_in)
    if (!rstn_in)
      prdata_ff <= 32'h0000_0000;
    else if (psel_in && !penable_in)
      prdata_ff <= rd_word;

  // Output registers
  axis_vec_t step_ff, dir_ff;
  always_ff @(posedge ref_clk_in or negedge rstn_in)
    if (!rstn_in)
    begin
      step_ff <= 8'h00;
      dir_ff <= 8'h00;
    end
    else
    begin
      step_ff <= step_in & chan_mask;
      dir_ff <= dir_in & chan_mask;
    end

  assign prdata_out = prdata_ff;
  assign pready_out = psel_in && penable_in;
  assign pslverr_out = psel_in && penable_in && !rd_hit;
  assign irq_out = |(status_ff & mask_ff);
  assign step_out = step_ff;
  assign dir_out = dir_ff;
  assign axis_en_out = axis_en_ff;
  assign charge_pump_out = cp_ff;
  assign home_filt_out = home_f;
  assign limit_filt_out = limit_f;
  assign probe_out = probe_ff;
  assign running_out = running_ff;
  assign backoff_step_out = bo_step_ff;
  assign axis_done_out = done_ff;
  assign bl_req_out = bl_req_ff;
  assign bl_width_out = bl_width_ff;
  assign bl_accel_out = bl_accel_ff;
  assign buf_ms_out = buf_ms_ff;
  assign sync_out = sync_ff;

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);
  sequence s_rev;
    bl_en && chan_mask[0] && (dir_in[0] != dir_prev_ff[0]);
  endsequence
  sequence s_bo_pulse;
    bo_step_ff[0] ##1 !bo_step_ff[0];
  endsequence
  a_pump_idle: assert property (!running_ff |=> !cp_ff)
    else $error("charge pump moved while not running");
  a_pump_tick: assert property (running_ff && cp_en && tick
    && $past(running_ff) |=> cp_ff != $past(cp_ff))
    else $error("charge pump missed a tick toggle");
  a_estop_halt: assert property (estop_act |=> !running_ff)
    else $error("running while stop active");
  a_filter_hold: assert property (filter_ff != 8'h00
    && $rose(home_act[0]) |-> !home_f[0])
    else $error("home passed unfiltered");
  a_filter_pass: assert property (filter_ff == 8'h00 |->
    home_f == home_act)
    else $error("bypass filter delayed");
  a_en_follow: assert property (!host_mode && $stable(ctrl_ff) |=>
    axis_en_ff == (({8{$past(running_ff)}} & $past(chan_mask))
    ^ $past(en_pol_ff)))
    else $error("enable not following run");
  a_err_ignore: assert property (err_stop_ff == 8'h00 |-> !err_any)
    else $error("masked driver error acted");
  a_sync_hold: assert property (!apply |=> $stable(sync_ff))
    else $error("sync output changed mid move");
  a_ch8_off: assert property (sync_en |=> !step_ff[7])
    else $error("channel 8 stepping with sync on");
  a_backoff_step: assert property (bo_busy_ff[0] && tick
    && !homing_done_in[0] |=> s_bo_pulse)
    else $error("back-off step missing");
  a_bl_req: assert property (s_rev |=> bl_req_ff[0])
    else $error("backlash request missing");
  a_buf_max: assert property (buf_ms_ff <= `BUF_MS_MAX)
    else $error("buffer size above limit");
endmodule

/* src/step_axis_io_supervisor_defs.svh */
// Offsets, field positions, reset values and timing counts of the
// axis I/O supervisor. Assumes a 250 MHz clock and APB byte addresses.
`ifndef STEP_AXIS_IO_SUPERVISOR_DEFS_SVH
`define STEP_AXIS_IO_SUPERVISOR_DEFS_SVH
`define OFF_CTRL 8'h00
`define OFF_FILTER 8'h04
`define OFF_HOST_EN 8'h08
`define OFF_EN_POL 8'h0C
`define OFF_ERR_STOP 8'h10
`define OFF_ERR_INV 8'h14
`define OFF_BACKOFF 8'h18
`define OFF_BL_ACCEL 8'h1C
`define OFF_BL_WIDTH 8'h20
`define OFF_SYNC_CMD 8'h24
`define OFF_STATUS 8'h28
`define OFF_MASK 8'h2C
`define OFF_STATE 8'h30
`define OFF_BUF_MS 8'h34
`define OFF_SYNC_OUT 8'h38
`define CTRL_RUN 0
`define CTRL_ESTOP_INV 1
`define CTRL_CP_EN 2
`define CTRL_HOST_EN 3
`define CTRL_SYNC_EN 4
`define CTRL_BL_EN 5
`define CTRL_PROBE_INV 6
`define CTRL_EXT_IO 7
`define CTRL_VAR_LO 8
`define CTRL_VAR_HI 9
`define CTRL_W 10
`define SYNC_IDX_HI 2
`define SYNC_CODE_BIT 8
`define ST_ESTOP 0
`define ST_DRV_ERR 1
`define ST_BACKOFF 2
`define ST_PROBE 3
`define ST_LIMIT 4
`define ST_W 5
`define CTRL_RST 10'h000
`define FILTER_MAX 8'hFE
`define BUF_MS_MAX 8'h80
`define BUF_MS_RST 8'h80
`define CLK_PERIOD_NS 4
`define TICK_TIME_NS 100000
`define TICK_CYCLES (`TICK_TIME_NS / `CLK_PERIOD_NS)
`define SYNC_STAGES 26
`endif

/* src/step_axis_io_supervisor_pkg.sv */
// Types shared by the axis I/O supervisor.
// Assumes the constants header is included alongside.
package step_axis_io_supervisor_pkg;
  typedef logic [7:0] axis_vec_t;
  typedef enum logic [1:0] {
    VAR_INT3 = 2'h0,
    VAR_EXT4 = 2'h1,
    VAR_EXT8 = 2'h2
  } engine_var_t;
  typedef enum logic {
    SYNC_CLEAR_CODE = 1'b0,
    SYNC_SET_CODE = 1'b1
  } sync_code_t;
endpackage
